/* File: byte_queue.sv */
// byte_queue: 4096-byte circular store with fill level and overflow policy
// assumes push and pop never come from the same source in one cycle
`timescale 1ns/1ps
`default_nettype none
module byte_queue (
    input wire logic sys_clk,
    input wire logic srst,
    queue_if.store q
);
    logic [7:0] mem [sensor_queue_pkg::QUEUE_DEPTH];
    logic [sensor_queue_pkg::PTR_W-1:0] wr_ptr;
    logic [sensor_queue_pkg::PTR_W-1:0] rd_ptr;
    logic [sensor_queue_pkg::COUNT_W-1:0] level;
    logic take;
    logic accept;
    logic evict;

    always_comb begin
        take = q.pop && (level != '0) && !q.clear;
        accept = q.push && !q.clear && !(q.full && q.drop_when_full && !take);
        evict = accept && q.full && !take;
    end

    always_ff @(posedge sys_clk) begin
        if (accept) begin
            mem[wr_ptr] <= q.push_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || q.clear) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (accept) begin
                wr_ptr <= wr_ptr + 12'h001;
            end
            if (take || evict) begin
                rd_ptr <= rd_ptr + 12'h001;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || q.clear) begin
            level <= '0;
        end else if (accept && !evict && !take) begin
            level <= level + 13'h0001;
        end else if (take && !accept) begin
            level <= level - 13'h0001;
        end
    end

    assign q.level = level;
    assign q.full = level == sensor_queue_pkg::QUEUE_FULL_LEVEL;
    assign q.head = mem[rd_ptr];

    chk_clear_holds_empty: assert property (@(posedge sys_clk) disable iff (srst)
        q.clear [*2] |-> level == '0)
        else $error("queue not empty while reset field held");

    chk_snapshot_drops: assert property (@(posedge sys_clk) disable iff (srst)
        (q.full && q.drop_when_full && q.push && !q.pop && !q.clear)
        |=> level == $past(level) && wr_ptr == $past(wr_ptr))
        else $error("snapshot mode wrote into a full queue");

    chk_count_step: assert property (@(posedge sys_clk) disable iff (srst)
        (q.push && !q.pop && !q.full && !q.clear) |=> level == $past(level) + 13'h0001)
        else $error("level did not rise by one on push");

    chk_stream_evict: assert property (@(posedge sys_clk) disable iff (srst)
        (q.push && q.full && !q.drop_when_full && !q.pop && !q.clear)
        |=> level == $past(level) && rd_ptr == $past(rd_ptr) + 12'h001)
        else $error("stream mode did not evict the oldest byte");
endmodule // byte_queue
`default_nettype wire

/* File: host_model.sv */
// host_model: apb master standing in for the host processor
// assumes zero or more wait states, pready sampled at rising edges
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic sys_clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end

    // released lines show the inverse, so a stale address never looks valid
    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
            output logic [31:0] rdata, output logic err);
        rdata = 'x;
        err = 1'bx;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge sys_clk);
        penable <= 1'b1;
        // no wait limit here: the bench timeout ends a hung transfer
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~addr;
        pwdata <= ~wdata;
    endtask

    task automatic write(input logic [11:0] addr, input logic [31:0] wdata);
        logic [31:0] d;
        logic e;
        xfer(1'b1, addr, wdata, d, e);
    endtask

    task automatic read(input logic [11:0] addr, output logic [31:0] d, output logic e);
        xfer(1'b0, addr, 32'h0000_0000, d, e);
    endtask

    task automatic flush();
        write({2'b00, sensor_queue_pkg::IDX_RESET_CTL, 2'b00}, 32'h0000_001f);
        write({2'b00, sensor_queue_pkg::IDX_RESET_CTL, 2'b00}, 32'h0000_0000);
    endtask

    task automatic read_level(output logic [31:0] hi, output logic [31:0] lo);
        logic e;
        read({2'b00, sensor_queue_pkg::IDX_COUNT_HI, 2'b00}, hi, e);
        read({2'b00, sensor_queue_pkg::IDX_COUNT_LO, 2'b00}, lo, e);
    endtask
endmodule // host_model
`default_nettype wire

/* File: queue_if.sv */
// queue_if: push, pop and status lines between the control logic and the byte store
// assumes both ends run on sys_clk
`timescale 1ns/1ps
`default_nettype none
interface queue_if;
    logic push;
    logic [7:0] push_data;
    logic pop;
    logic clear;
    logic drop_when_full;
    logic [7:0] head;
    logic [sensor_queue_pkg::COUNT_W-1:0] level;
    logic full;
    modport ctrl (output push, push_data, pop, clear, drop_when_full, input head, level, full);
    modport store (input push, push_data, pop, clear, drop_when_full, output head, level, full);
endinterface
`default_nettype wire

/* File: sample_sequencer.sv */
// sample_sequencer: turns one sample tick into a burst of enabled output bytes
// assumes sensor words are stable on sys_clk and ticks are at least 15 cycles apart
`timescale 1ns/1ps
`default_nettype none
module sample_sequencer (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic sample_tick,
    input wire logic hold,
    input wire logic [4:0] enables,
    input wire logic [15:0] accel_x,
    input wire logic [15:0] accel_y,
    input wire logic [15:0] accel_z,
    input wire logic [15:0] rate_x,
    input wire logic [15:0] rate_y,
    input wire logic [15:0] rate_z,
    input wire logic [15:0] temp_word,
    output logic push,
    output logic [7:0] push_data
);
    localparam int FB = sensor_queue_pkg::FRAME_BYTES;
    logic [FB*8-1:0] frame;
    logic [FB-1:0] mask;
    logic [sensor_queue_pkg::STEP_W-1:0] step;
    logic [sensor_queue_pkg::STEP_W-1:0] sent;
    logic [7:0] accel_x_high;
    sensor_queue_pkg::seq_state_e state;

    // byte k of the frame sits at [8k+:8], so high byte goes first
    function automatic logic [15:0] swap16(input logic [15:0] w);
        return {w[7:0], w[15:8]};
    endfunction

    always_ff @(posedge sys_clk) begin
        if (state == sensor_queue_pkg::SEQ_IDLE && sample_tick) begin
            frame <= {swap16(temp_word), swap16(rate_z), swap16(rate_y), swap16(rate_x),
                swap16(accel_z), swap16(accel_y), swap16(accel_x)};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mask <= '0;
        end else if (state == sensor_queue_pkg::SEQ_IDLE && sample_tick) begin
            mask[5:0] <= {6{enables[sensor_queue_pkg::ACCEL_EN_BIT]}};
            mask[7:6] <= {2{enables[sensor_queue_pkg::RATE_X_EN_BIT]}};
            mask[9:8] <= {2{enables[sensor_queue_pkg::RATE_Y_EN_BIT]}};
            mask[11:10] <= {2{enables[sensor_queue_pkg::RATE_Z_EN_BIT]}};
            mask[13:12] <= {2{enables[sensor_queue_pkg::TEMP_EN_BIT]}};
        end
    end

    // a tick during a burst is ignored rather than queued
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= sensor_queue_pkg::SEQ_IDLE;
            step <= '0;
        end else begin
            unique case (state)
                sensor_queue_pkg::SEQ_IDLE: if (sample_tick) begin
                    state <= sensor_queue_pkg::SEQ_SEND;
                    step <= '0;
                end
                sensor_queue_pkg::SEQ_SEND: if (!hold) begin
                    if (step == sensor_queue_pkg::LAST_STEP) begin
                        state <= sensor_queue_pkg::SEQ_IDLE;
                    end
                    step <= step + 4'h1;
                end
            endcase
        end
    end

    assign push = (state == sensor_queue_pkg::SEQ_SEND) && !hold && mask[step];
    assign push_data = frame[{step, 3'b000} +: 8];
    assign accel_x_high = accel_x[15:8];

    always_ff @(posedge sys_clk) begin
        if (srst || state == sensor_queue_pkg::SEQ_IDLE) begin
            sent <= '0;
        end else if (push) begin
            sent <= sent + 4'h1;
        end
    end

    sequence frame_start;
        state == sensor_queue_pkg::SEQ_IDLE && sample_tick;
    endsequence

    chk_accel_lead: assert property (@(posedge sys_clk) disable iff (srst)
        (frame_start ##0 enables[sensor_queue_pkg::ACCEL_EN_BIT]) ##1 !hold
        |-> push && push_data == $past(accel_x_high))
        else $error("frame did not open with accel x high byte");

    chk_frame_length: assert property (@(posedge sys_clk) disable iff (srst)
        (state == sensor_queue_pkg::SEQ_SEND && step == sensor_queue_pkg::LAST_STEP && !hold)
        |-> int'(sent) + int'(push) == $countones(mask))
        else $error("burst length differs from enabled sources");

    chk_disabled_silent: assert property (@(posedge sys_clk) disable iff (srst)
        (frame_start ##0 !enables[sensor_queue_pkg::RATE_Z_EN_BIT])
        |=> ##5 (!(push && (step == 4'ha || step == 4'hb))) [*8])
        else $error("disabled z rate bytes were pushed");
endmodule // sample_sequencer
`default_nettype wire

/* File: sensor_fifo_control.sv */
// sensor_fifo_control: sample queue control behind an apb register slave
// assumes sample_tick and sensor words come from logic on sys_clk
// How it works
// - accel enable pushes six accel bytes
// - z rate enable pushes its pair
// - y rate enable pushes its pair
// - x rate enable pushes its pair
// - temperature enable pushes its pair
// - held reset field keeps level zero
// - set then clear reset empties queue
// - stream mode keeps writing when full
// - snapshot mode drops writes when full
// - high count holds bits twelve to eight
// - low count holds bits seven to zero
// - high read latches both count bytes
// - data port read pops, write pushes
`timescale 1ns/1ps
`default_nettype none
module sensor_fifo_control (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_tick,
    input wire logic [15:0] accel_x,
    input wire logic [15:0] accel_y,
    input wire logic [15:0] accel_z,
    input wire logic [15:0] rate_x,
    input wire logic [15:0] rate_y,
    input wire logic [15:0] rate_z,
    input wire logic [15:0] temp_word
);
    logic [sensor_queue_pkg::FIELD_W-1:0] capture_en;
    logic [sensor_queue_pkg::FIELD_W-1:0] reset_field;
    logic [sensor_queue_pkg::FIELD_W-1:0] policy_field;
    logic [sensor_queue_pkg::COUNT_W-1:0] count_snap;
    logic [31:0] read_word;
    logic sel_cap;
    logic sel_rst;
    logic sel_pol;
    logic sel_hi;
    logic sel_lo;
    logic sel_data;
    logic mapped;
    logic bad;
    logic setup;
    logic access;
    logic wr_done;
    logic rd_done;
    logic host_push;
    logic seq_hold;
    logic seq_push;
    logic [7:0] seq_data;

    queue_if q ();

    byte_queue u_queue (
        .sys_clk(sys_clk),
        .srst(srst),
        .q(q)
    );

    sample_sequencer u_seq (
        .sys_clk(sys_clk),
        .srst(srst),
        .sample_tick(sample_tick),
        .hold(seq_hold),
        .enables(capture_en),
        .accel_x(accel_x),
        .accel_y(accel_y),
        .accel_z(accel_z),
        .rate_x(rate_x),
        .rate_y(rate_y),
        .rate_z(rate_z),
        .temp_word(temp_word),
        .push(seq_push),
        .push_data(seq_data)
    );

    // address decode
    always_comb begin
        sel_cap = sensor_queue_pkg::at_reg(paddr, sensor_queue_pkg::IDX_CAPTURE_EN);
        sel_rst = sensor_queue_pkg::at_reg(paddr, sensor_queue_pkg::IDX_RESET_CTL);
        sel_pol = sensor_queue_pkg::at_reg(paddr, sensor_queue_pkg::IDX_POLICY);
        sel_hi = sensor_queue_pkg::at_reg(paddr, sensor_queue_pkg::IDX_COUNT_HI);
        sel_lo = sensor_queue_pkg::at_reg(paddr, sensor_queue_pkg::IDX_COUNT_LO);
        sel_data = sensor_queue_pkg::at_reg(paddr, sensor_queue_pkg::IDX_DATA_PORT);
        mapped = sel_cap || sel_rst || sel_pol || sel_hi || sel_lo || sel_data;
        // count registers are read only, so a write to them is an error
        bad = !mapped || (pwrite && (sel_hi || sel_lo));
    end

    // zero wait states: every access phase completes
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr_done = access && pwrite && !bad;
    assign rd_done = access && !pwrite && !bad;
    assign pready = 1'b1;
    assign pslverr = access && bad;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            capture_en <= sensor_queue_pkg::CAPTURE_EN_RST;
        end else if (wr_done && sel_cap) begin
            capture_en <= pwdata[sensor_queue_pkg::FIELD_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reset_field <= sensor_queue_pkg::RESET_CTL_RST;
        end else if (wr_done && sel_rst) begin
            reset_field <= pwdata[sensor_queue_pkg::FIELD_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            policy_field <= sensor_queue_pkg::POLICY_RST;
        end else if (wr_done && sel_pol) begin
            policy_field <= pwdata[sensor_queue_pkg::FIELD_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            count_snap <= sensor_queue_pkg::COUNT_SNAP_RST;
        end else if (setup && !pwrite && sel_hi) begin
            count_snap <= q.level;
        end
    end

    always_comb begin
        read_word = '0;
        if (sel_cap) begin
            read_word[sensor_queue_pkg::FIELD_W-1:0] = capture_en;
        end else if (sel_rst) begin
            read_word[sensor_queue_pkg::FIELD_W-1:0] = reset_field;
        end else if (sel_pol) begin
            read_word[sensor_queue_pkg::FIELD_W-1:0] = policy_field;
        end else if (sel_hi) begin
            read_word[4:0] = q.level[12:8];
        end else if (sel_lo) begin
            read_word[7:0] = count_snap[7:0];
        end else if (sel_data && q.level != '0) begin
            read_word[7:0] = q.head;
        end
    end

    // read data is captured in setup so it is stable through the access phase
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prdata <= '0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : read_word;
        end
    end

    // sequencer stalls over a data port transfer, so the byte read is the byte popped
    assign seq_hold = psel && sel_data;
    assign host_push = wr_done && sel_data;

    assign q.pop = rd_done && sel_data;
    assign q.push = host_push || seq_push;
    assign q.push_data = host_push ? pwdata[7:0] : seq_data;
    assign q.clear = |reset_field;
    assign q.drop_when_full = policy_field[sensor_queue_pkg::SNAPSHOT_BIT];

    sequence hi_read_setup;
        setup && !pwrite && sel_hi;
    endsequence

    sequence lo_read_setup;
        setup && !pwrite && sel_lo;
    endsequence

    sequence rst_assert_write;
        wr_done && sel_rst && pwdata[sensor_queue_pkg::FIELD_W-1:0] != '0;
    endsequence

    sequence data_read_setup;
        setup && !pwrite && sel_data;
    endsequence

    sequence full_push;
        q.push && q.full && !q.pop && !q.clear;
    endsequence

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    chk_count_hi_layout: assert property (@(posedge sys_clk) disable iff (srst)
        hi_read_setup
        |=> prdata[31:5] == '0 && prdata[4:0] == $past(q.level[12:8]))
        else $error("high count byte wrong");

    // host leaves one idle cycle between transfers
    chk_count_pair: assert property (@(posedge sys_clk) disable iff (srst)
        hi_read_setup ##3 lo_read_setup
        |=> prdata[7:0] == $past(q.level[7:0], 4))
        else $error("low count byte not latched with high");

    chk_count_lo_upper: assert property (@(posedge sys_clk) disable iff (srst)
        lo_read_setup |=> prdata[31:8] == '0 && prdata[7:0] == $past(count_snap[7:0]))
        else $error("low count byte wrong");

    chk_reset_empties: assert property (@(posedge sys_clk) disable iff (srst)
        rst_assert_write |=> q.clear ##1 q.level == '0)
        else $error("reset field write did not empty queue");

    chk_reset_release: assert property (@(posedge sys_clk) disable iff (srst)
        (wr_done && sel_rst && pwdata[sensor_queue_pkg::FIELD_W-1:0] == '0) |=> !q.clear)
        else $error("queue still held after reset release");

    chk_pop_on_read: assert property (@(posedge sys_clk) disable iff (srst)
        (rd_done && sel_data && q.level != '0 && !q.clear)
        |=> q.level == $past(q.level) - 13'h0001)
        else $error("data port read did not pop");

    chk_push_on_write: assert property (@(posedge sys_clk) disable iff (srst)
        (host_push && !q.full && !q.clear) |=> q.level == $past(q.level) + 13'h0001)
        else $error("data port write did not push");

    chk_stream_full: assert property (@(posedge sys_clk) disable iff (srst)
        full_push ##0 !q.drop_when_full
        |=> q.full)
        else $error("stream mode lost fill when full");

    chk_slave_error: assert property (@(posedge sys_clk) disable iff (srst)
        (access && pwrite && sel_hi)
        |-> pslverr && !wr_done)
        else $error("write to count register not refused");

    chk_empty_read_zero: assert property (
        data_read_setup ##0 q.level == '0
        |=> prdata == '0)
        else $error("empty data port read not zero");

    chk_seq_stalls: assert property (
        psel && sel_data
        |-> !seq_push)
        else $error("sample push during data port transfer");

    chk_snapshot_keeps: assert property (
        full_push ##0 q.drop_when_full
        |=> q.full && $stable(q.head))
        else $error("snapshot mode changed a full queue");

    chk_lo_write_refused: assert property (
        access && pwrite && sel_lo
        |-> pslverr && !wr_done)
        else $error("write to low count not refused");

    chk_unmapped_error: assert property (
        access && !mapped
        |-> pslverr)
        else $error("unmapped access not refused");

    chk_unmapped_read: assert property (
        setup && !pwrite && !mapped
        |=> prdata == '0)
        else $error("unmapped read returned data");

    chk_enable_store: assert property (
        wr_done && sel_cap
        |=> capture_en == $past(pwdata[sensor_queue_pkg::FIELD_W-1:0]))
        else $error("capture enables not stored");

    chk_policy_store: assert property (
        wr_done && sel_pol
        |=> q.drop_when_full == $past(pwdata[sensor_queue_pkg::SNAPSHOT_BIT]))
        else $error("overflow policy not stored");

    chk_field_holds: assert property (
        wr_done && sel_rst
        |=> q.clear == ($past(pwdata[sensor_queue_pkg::FIELD_W-1:0]) != '0))
        else $error("reset field does not gate the queue");

    chk_hi_latch: assert property (
        hi_read_setup
        |=> count_snap == $past(q.level))
        else $error("high read did not latch the level");

    chk_latch_steady: assert property (
        !(setup && !pwrite && sel_hi)
        |=> $stable(count_snap))
        else $error("count latch moved without a high read");
endmodule // sensor_fifo_control
`default_nettype wire

/* File: sensor_fifo_control_test.sv */
// sensor_fifo_control_test: self-checking bench for the sample queue control
// assumes host_model drives the apb side; bench drives ticks and sensor words
`timescale 1ns/1ps
`default_nettype none
module sensor_fifo_control_test;
    logic sys_clk, srst, sample_tick, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] words [7];
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    // enable bit per word: accel x y z, rate x y z, temperature
    int en_bit [7] = '{4, 4, 4, 1, 2, 3, 0};
    logic [11:0] a_en = {2'b00, sensor_queue_pkg::IDX_CAPTURE_EN, 2'b00};
    logic [11:0] a_rst = {2'b00, sensor_queue_pkg::IDX_RESET_CTL, 2'b00};
    logic [11:0] a_pol = {2'b00, sensor_queue_pkg::IDX_POLICY, 2'b00};
    logic [11:0] a_hi = {2'b00, sensor_queue_pkg::IDX_COUNT_HI, 2'b00};
    logic [11:0] a_lo = {2'b00, sensor_queue_pkg::IDX_COUNT_LO, 2'b00};
    logic [11:0] a_dat = {2'b00, sensor_queue_pkg::IDX_DATA_PORT, 2'b00};

    sensor_fifo_control dut_u (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_tick(sample_tick), .accel_x(words[0]), .accel_y(words[1]),
        .accel_z(words[2]), .rate_x(words[3]), .rate_y(words[4]), .rate_z(words[5]),
        .temp_word(words[6]));
    host_model host_u (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // word high byte is the sample number, low byte names the source
    task automatic tick(input logic [7:0] k);
        @(posedge sys_clk);
        for (int i = 0; i < 7; i++) words[i] <= {k, 8'(i + 1)};
        sample_tick <= 1'b1;
        @(posedge sys_clk);
        sample_tick <= 1'b0;
        repeat (15) @(posedge sys_clk);
    endtask

    task automatic expect_level(input logic [12:0] lvl);
        logic [31:0] hi, lo;
        host_u.read_level(hi, lo);
        check(hi, {27'h0, lvl[12:8]}, "count high");
        check(lo, {24'h0, lvl[7:0]}, "count low");
    endtask

    task automatic test_registers();
        logic [31:0] d;
        logic e;
        host_u.read(a_en, d, e);
        check(d, 32'h0, "enables reset");
        host_u.read(a_rst, d, e);
        check(d, 32'h0, "reset field reset");
        host_u.read(a_pol, d, e);
        check(d, 32'h0, "policy reset");
        expect_level(13'h0000);
        host_u.write(a_en, 32'hffff_ffff);
        host_u.read(a_en, d, e);
        check(d, 32'h1f, "enables readback");
        host_u.write(a_en, 32'h0);
        host_u.xfer(1'b1, a_hi, 32'hffff_ffff, d, e);
        check({31'h0, e}, 32'h1, "count high write refused");
        @(posedge sys_clk);
        check({31'h0, pslverr}, 32'h0, "idle error");
        host_u.xfer(1'b1, a_lo, 32'h55, d, e);
        check({31'h0, e}, 32'h1, "count write refused");
        host_u.read(12'h1cc, d, e);
        check({e, d[30:0]}, 32'h8000_0000, "unmapped read");
        host_u.read(a_dat, d, e);
        check(d, 32'h0, "empty pop");
        expect_level(13'h0000);
        $display("test registers done");
    endtask

    task automatic test_capture();
        logic [4:0] masks [7] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h00, 5'h1f};
        logic [7:0] exp_q [$];
        logic [31:0] d;
        logic e;
        foreach (masks[m]) begin
            host_u.write(a_en, {27'h0, masks[m]});
            tick(8'(m + 8'h40));
            exp_q.delete();
            for (int s = 0; s < 14; s++) begin
                if (masks[m][en_bit[s / 2]]) exp_q.push_back(s[0] ? 8'(s / 2 + 1) : 8'(m + 8'h40));
            end
            expect_level(13'(exp_q.size()));
            foreach (exp_q[i]) begin
                host_u.read(a_dat, d, e);
                check(d, {24'h0, exp_q[i]}, "popped byte");
            end
            expect_level(13'h0000);
        end
        host_u.write(a_en, 32'h0);
        $display("test capture done");
    endtask

    task automatic test_reset_hold();
        logic [31:0] d;
        logic e;
        host_u.write(a_dat, 32'ha5);
        host_u.write(a_en, 32'h1f);
        host_u.write(a_rst, 32'h1f);
        tick(8'h11);
        host_u.write(a_dat, 32'h5a);
        expect_level(13'h0000);
        host_u.write(a_rst, 32'h0);
        host_u.write(a_en, 32'h0);
        expect_level(13'h0000);
        host_u.write(a_dat, 32'h3c);
        host_u.read(a_hi, d, e);
        host_u.write(a_dat, 32'h3d);
        host_u.read(a_lo, d, e);
        check(d, 32'h01, "latched low");
        expect_level(13'h0002);
        host_u.read(a_dat, d, e);
        check(d, 32'h3c, "first after reset");
        host_u.read(a_dat, d, e);
        check(d, 32'h3d, "second after reset");
        $display("test reset hold done");
    endtask

    // 300 bursts of 14 overrun 4096; stream evicts 104 oldest bytes
    task automatic test_overflow(input logic snap);
        logic [31:0] d;
        logic e;
        host_u.write(a_pol, {31'h0, snap});
        host_u.flush();
        host_u.write(a_en, 32'h1f);
        for (int k = 0; k < 300; k++) tick(8'(k));
        host_u.write(a_en, 32'h0);
        expect_level(13'h1000);
        host_u.read(a_dat, d, e);
        check(d, snap ? 32'h00 : 32'h07, "oldest byte");
        expect_level(13'h0fff);
        $display("test overflow done");
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fail_count++;
            $display("BAD %0t timeout", $time);
            final_report();
        end
    end

    initial begin
        srst = 1'b1;
        sample_tick = 1'b0;
        foreach (words[i]) words[i] = 16'h0000;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        test_registers();
        test_capture();
        test_reset_hold();
        test_overflow(1'b1);
        test_overflow(1'b0);
        final_report();
    end
endmodule // sensor_fifo_control_test
`default_nettype wire

/* File: sensor_queue_pkg.sv */
// sensor_queue_pkg: register map, field layout and sizes of the sample queue
// assumes apb byte addressing with one register per aligned 32-bit word
package sensor_queue_pkg;
    localparam int ADDR_W = 12;
    localparam int COUNT_W = 13;
    localparam int PTR_W = 12;
    localparam int QUEUE_DEPTH = 4096;
    localparam logic [COUNT_W-1:0] QUEUE_FULL_LEVEL = 13'h1000;
    localparam logic [COUNT_W-1:0] COUNT_SNAP_RST = 13'h0000;
    localparam int FRAME_BYTES = 14;
    localparam int STEP_W = 4;
    localparam logic [STEP_W-1:0] LAST_STEP = 4'hd;

    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_CAPTURE_EN = 8'h67;
    localparam logic [7:0] IDX_RESET_CTL = 8'h68;
    localparam logic [7:0] IDX_POLICY = 8'h69;
    localparam logic [7:0] IDX_COUNT_HI = 8'h70;
    localparam logic [7:0] IDX_COUNT_LO = 8'h71;
    localparam logic [7:0] IDX_DATA_PORT = 8'h72;

    localparam int FIELD_W = 5;
    localparam int ACCEL_EN_BIT = 4;
    localparam int RATE_Z_EN_BIT = 3;
    localparam int RATE_Y_EN_BIT = 2;
    localparam int RATE_X_EN_BIT = 1;
    localparam int TEMP_EN_BIT = 0;
    localparam int SNAPSHOT_BIT = 0;
    localparam logic [FIELD_W-1:0] CAPTURE_EN_RST = 5'h00;
    localparam logic [FIELD_W-1:0] RESET_CTL_RST = 5'h00;
    localparam logic [FIELD_W-1:0] POLICY_RST = 5'h00;

    typedef enum logic {SEQ_IDLE, SEQ_SEND} seq_state_e;

    function automatic logic at_reg(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        return addr == {2'b00, idx, 2'b00};
    endfunction
endpackage
